/* File: slsd_pkg.sv */
package slsd_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int unsigned STAGES     = 8;
   localparam int unsigned BUF_DEPTH  = 2;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  SHIFT_RST  = 8'h00;
   localparam logic [7:0]  LATCH_RST  = 8'h00;
   localparam logic [1:0]  SYNC_RST   = 2'h0;
   // Undriven defaults: blank high, strobe low
   localparam logic        BLANK_IDLE = 1'b1;
   localparam logic        STROBE_IDLE = 1'b0;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned T_SETUP_NS    = 50;
   localparam int unsigned SETUP_CYC     =
      (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : slsd_pkg

/* File: slsd_bit_buf.sv */
`timescale 1ns/1ns
`default_nettype none
module slsd_bit_buf (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Fill side
   input  wire logic inValid,
   output logic      inReady,
   input  wire logic inBit,
   // Drain side
   output logic      outValid,
   input  wire logic outReady,
   output logic      outBit
);
   logic [slsd_pkg::BUF_DEPTH-1:0] mem_r;
   logic                           wrIdx_r;
   logic                           rdIdx_r;
   logic [1:0]                     count_r;

   assign inReady  = (count_r != 2'(slsd_pkg::BUF_DEPTH));
   assign outValid = (count_r != 2'h0);
   assign outBit   = mem_r[rdIdx_r];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mem_r   <= 2'h0;
         wrIdx_r <= 1'b0;
      end else if (inValid && inReady) begin
         mem_r[wrIdx_r] <= inBit;
         wrIdx_r        <= ~wrIdx_r;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdIdx_r <= 1'b0;
      end else if (outValid && outReady) begin
         rdIdx_r <= ~rdIdx_r;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_r <= 2'h0;
      end else begin
         case ({inValid && inReady, outValid && outReady})
            2'b10:   count_r <= count_r + 2'h1;
            2'b01:   count_r <= count_r - 2'h1;
            default: count_r <= count_r;
         endcase
      end
   end
endmodule : slsd_bit_buf
`default_nettype wire

/* File: slsd_driver.sv */
// Summary of operation
// - Shift-clock rising edge captures shift_in_bit into first stage.
// - Each later rising edge moves every stage one step toward cascade output.
// - Strobe high: latches transparently follow the shift-register stages.
// - Blank high turns all eight sinks off.
// - Blanking never alters latch contents.
// - Blank low: each sink follows its own latch bit.
// - Exactly eight sink outputs, indices 0 to 7, one latch each.
// - Last stage drives cascade_bit_out for chaining.
// - Undriven blank reads high, undriven strobe reads low.
`timescale 1ns/1ns
`default_nettype none
module slsd_driver (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Serial pins from host
   input  wire logic       shiftClk,
   input  wire logic       shiftInBit,
   input  wire logic       parallelLoadStrobe,
   input  wire logic       parallelLoadStrobeDriven,
   input  wire logic       sinkBlank,
   input  wire logic       sinkBlankDriven,
   // Cascade output
   output logic            cascadeBitOut,
   // Sink drivers, high means sinking
   output logic [7:0]      sinkDrives
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [1:0] clkSync_r;
   logic [1:0] dataSync_r;
   logic [1:0] strobeSync_r;
   logic [1:0] blankSync_r;
   logic       clkPrev_r;
   logic       strobeIn;
   logic       blankIn;

   // An undriven pin reads as its pull level
   function automatic logic resolvePin(input logic driven,
                                       input logic level,
                                       input logic idle);
      return driven ? level : idle;
   endfunction : resolvePin

   // Pull defaults apply before sampling, so the idle state is synchronised too
   assign strobeIn = resolvePin(parallelLoadStrobeDriven, parallelLoadStrobe,
                                slsd_pkg::STROBE_IDLE);
   assign blankIn  = resolvePin(sinkBlankDriven, sinkBlank,
                                slsd_pkg::BLANK_IDLE);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clkSync_r    <= slsd_pkg::SYNC_RST;
         dataSync_r   <= slsd_pkg::SYNC_RST;
         strobeSync_r <= slsd_pkg::SYNC_RST;
         blankSync_r  <= {2{slsd_pkg::BLANK_IDLE}};
      end else begin
         clkSync_r    <= {clkSync_r[0], shiftClk};
         dataSync_r   <= {dataSync_r[0], shiftInBit};
         strobeSync_r <= {strobeSync_r[0], strobeIn};
         blankSync_r  <= {blankSync_r[0], blankIn};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clkPrev_r <= 1'b0;
      end else begin
         clkPrev_r <= clkSync_r[1];
      end
   end

   // ---------------------------------------------------------------
   // Edge detect and buffering
   // ---------------------------------------------------------------
   // Data is sampled together with the clock, so the host's hold time
   // keeps the bit stable through both synchronisers.
   logic shiftEdge;
   logic bufValid;
   logic bufBit;
   logic shiftTake;

   assign shiftEdge = clkSync_r[1] && !clkPrev_r;
   assign shiftTake = bufValid;

   // Two entries absorb an edge arriving while the register is busy;
   // the register drains one bit a cycle so it never really stalls.
   slsd_bit_buf u_buf (
      .core_clk (core_clk),
      .rst      (rst),
      .inValid  (shiftEdge),
      .inReady  (),
      .inBit    (dataSync_r[1]),
      .outValid (bufValid),
      .outReady (shiftTake),
      .outBit   (bufBit)
   );

   // ---------------------------------------------------------------
   // Shift register
   // ---------------------------------------------------------------
   logic [slsd_pkg::STAGES-1:0] shift_r;
   logic [slsd_pkg::STAGES-1:0] shift_nxt;

   always_comb begin
      shift_nxt = {shift_r[slsd_pkg::STAGES-2:0], bufBit};
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shift_r <= slsd_pkg::SHIFT_RST;
      end else if (shiftTake) begin
         shift_r <= shift_nxt;
      end
   end

   // Stage 7 is the eighth stage reached by the first bit
   assign cascadeBitOut = shift_r[slsd_pkg::STAGES-1];

   // ---------------------------------------------------------------
   // Latches
   // ---------------------------------------------------------------
   logic [slsd_pkg::STAGES-1:0] latch_r;

   // Blank is deliberately absent here so blanking cannot disturb contents
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         latch_r <= slsd_pkg::LATCH_RST;
      end else if (strobeSync_r[1]) begin
         latch_r <= shift_r;
      end
   end // Hold otherwise

   // ---------------------------------------------------------------
   // Sink drivers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sinkDrives <= 8'h00;
      end else if (blankSync_r[1]) begin
         sinkDrives <= 8'h00;
      end else begin
         sinkDrives <= latch_r;
      end
   end
endmodule : slsd_driver
`default_nettype wire

/* File: slsd_driver_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module slsd_driver_sva (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rst,
   // Pins
   input wire logic       shiftClk,
   input wire logic       shiftInBit,
   input wire logic       parallelLoadStrobe,
   input wire logic       parallelLoadStrobeDriven,
   input wire logic       sinkBlank,
   input wire logic       sinkBlankDriven,
   input wire logic       cascadeBitOut,
   input wire logic [7:0] sinkDrives
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Eight samples of the shift pin; no change means no shift in flight
   logic [7:0] hist_r;
   logic       moved, bLow;
   always_ff @(posedge core_clk) hist_r <= {hist_r[6:0], shiftClk};
   assign moved = hist_r != 8'h00 && hist_r != 8'hff;
   assign bLow  = sinkBlankDriven && !sinkBlank;
   blank_off_a: assert property (
      (sinkBlank && sinkBlankDriven)[*4] |-> sinkDrives == 8'h00) else $error("Blank ignored");
   blank_fast_a: assert property (
      $rose(sinkBlank && sinkBlankDriven) |-> ##[0:4] sinkDrives == 8'h00) else $error("Blank late");
   blank_pull_a: assert property (
      (!sinkBlankDriven)[*4] |-> sinkDrives == 8'h00) else $error("Open blank ignored");
   casc_quiet_a: assert property (
      $changed(cascadeBitOut) |-> moved) else $error("Cascade moved alone");
   latch_hold_a: assert property (
      (bLow && parallelLoadStrobeDriven && !parallelLoadStrobe)[*8] |-> $stable(sinkDrives))
      else $error("Latch moved");
   strobe_pull_a: assert property (
      (bLow && !parallelLoadStrobeDriven)[*8] |-> $stable(sinkDrives)) else $error("Open strobe");
   tap_match_a: assert property (
      (bLow && parallelLoadStrobe && parallelLoadStrobeDriven && !moved)[*6]
      |-> sinkDrives[7] == cascadeBitOut) else $error("Tap mismatch");
   latch_follow_a: assert property (
      (bLow && parallelLoadStrobe && parallelLoadStrobeDriven)[*8] ##1 $changed(cascadeBitOut)
      |-> ##[0:6] sinkDrives[7] == cascadeBitOut) else $error("Latch not following");
endmodule : slsd_driver_sva
bind slsd_driver slsd_driver_sva chk (.*);
`default_nettype wire

/* File: slsd_host.sv */
`timescale 1ns/1ns
`default_nettype none
module slsd_host (
   // Serial pins
   output logic shiftClk,
   output logic shiftInBit
);
   initial begin
      shiftClk = 1'b0;
      shiftInBit = 1'b0;
   end
   // Clock rests low between frames; data shows the inverse once hold runs out
   task automatic send(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         shiftInBit = v[i];
         #63 shiftClk = 1'b1;
         #30 shiftInBit = ~v[i];
         #32 shiftClk = 1'b0;
      end
   endtask : send
endmodule : slsd_host
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        core_clk, rst, sClk, sBit, casc, strb, strbDrv, blank, blankDrv;
   logic [7:0]  sinks;
   int          failures, compares, cycles;
   logic [15:0] rows [5] = '{16'h0000, 16'hffff, 16'ha5a5, 16'h0101, 16'h8181};
   slsd_driver dut (.core_clk(core_clk), .rst(rst), .shiftClk(sClk), .shiftInBit(sBit),
      .parallelLoadStrobe(strb), .parallelLoadStrobeDriven(strbDrv), .sinkBlank(blank),
      .sinkBlankDriven(blankDrv), .cascadeBitOut(casc), .sinkDrives(sinks));
   slsd_host host (.shiftClk(sClk), .shiftInBit(sBit));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         results();
      end
   end
   task automatic check(input logic [7:0] seen, exp, input string what);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Pins are {strobe, strobe driven, blank, blank driven}
   task automatic drive(input logic [3:0] p, input int n);
      @(negedge core_clk);
      {strb, strbDrv, blank, blankDrv} = p;
      repeat (n) @(negedge core_clk);
   endtask : drive
   task automatic results();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   initial begin
      {strb, strbDrv, blank, blankDrv} = 4'h5;
      rst = 1'b1;
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      foreach (rows[i]) begin
         host.send(rows[i][15:8]);
         drive(4'h5, 8);
         drive(4'hd, 10);
         drive(4'h5, 8);
         check(sinks, rows[i][7:0], "sinks");
         check({7'h00, casc}, {7'h00, rows[i][7]}, "cascade");
      end
      host.send(8'h3c);
      drive(4'h5, 12);
      check(sinks, 8'h81, "held");
      drive(4'h7, 8);
      check(sinks, 8'h00, "blanked");
      drive(4'h5, 8);
      check(sinks, 8'h81, "unblanked");
      drive(4'h4, 8);
      check(sinks, 8'h00, "open blank");
      drive(4'h9, 8);
      check(sinks, 8'h81, "open strobe");
      drive(4'hf, 4);
      host.send(8'hc3);
      drive(4'hf, 8);
      check(sinks, 8'h00, "bypass");
      drive(4'hd, 8);
      check(sinks, 8'hc3, "bypass shown");
      host.send(8'h96);
      drive(4'hd, 10);
      check(sinks, 8'h96, "follow");
      rst = 1'b1;
      drive(4'hd, 2);
      check(sinks, 8'h00, "reset sinks");
      check({7'h00, casc}, 8'h00, "reset cascade");
      rst = 1'b0;
      drive(4'hd, 6);
      check(sinks, 8'h00, "after reset");
      results();
   end
endmodule : tb
`default_nettype wire
